// ===== inc/wdc_regs.svh
// register map, field positions, reset values and timing constants of the watchdog block
`ifndef WDC_REGS_SVH
`define WDC_REGS_SVH

`define WDC_ADDR_W            4
`define WDC_ADDR_CAUSE        4'h0
`define WDC_ADDR_CONTROL      4'h1

`define WDC_DATA_W            8
`define WDC_DATA_ZERO         8'h00

// reset_cause_status fields
`define WDC_BIT_DBG_DISABLE   7
`define WDC_BIT_SCAN_FLAG     4
`define WDC_BIT_WDT_FLAG      3
`define WDC_BIT_BOR_FLAG      2
`define WDC_BIT_PIN_FLAG      1
`define WDC_BIT_POR_FLAG      0
`define WDC_FLAG_W            5
`define WDC_FLAGS_POR_RESET   5'h01
`define WDC_FLAGS_CLEAR       5'h00
`define WDC_FLAGS_ALL         5'h1f
`define WDC_FLAGS_LEGACY      5'h03

// watchdog_control fields
`define WDC_BIT_UNLOCK        4
`define WDC_BIT_ENABLE        3
`define WDC_SEL_HI            2
`define WDC_SEL_LO            0
`define WDC_SEL_W             3
`define WDC_SEL_RESET         3'h0

// timing
`define WDC_UNLOCK_CYCLES     3'h4
`define WDC_UNLOCK_ZERO       3'h0
`define WDC_OSC_PERIOD_NS     1000
`define WDC_BASE_EXP          14
`define WDC_CNT_W             22

// synchroniser lanes
`define WDC_SYNC_W            6
`define WDC_SYNC_OSC          0
`define WDC_SYNC_PIN          1
`define WDC_SYNC_BOR          2
`define WDC_SYNC_SCAN         3
`define WDC_SYNC_LEGACY       4
`define WDC_SYNC_ALWAYS_ON    5

`endif

// ===== inc/wdc_pkg.sv
// types shared by the watchdog block
package wdc_pkg;

  typedef enum logic [1:0] {
    SAFETY_L0,
    SAFETY_L1,
    SAFETY_L2
  } safety_level_t;

endpackage

// ===== rtl/watchdog_with_reset_cause.sv
// watchdog timer with safety levels and a reset-cause status register
//
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "wdc_regs.svh"

module watchdog_with_reset_cause #(
  parameter int CNT_W    = `WDC_CNT_W,
  parameter int BASE_EXP = `WDC_BASE_EXP
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_wdt_osc_clk,
  input  wire logic                   i_pin_reset,
  input  wire logic                   i_brownout_reset,
  input  wire logic                   i_scan_reset,
  input  wire logic                   i_legacy_compat_fuse,
  input  wire logic                   i_always_on_fuse,
  input  wire logic                   i_restart_instruction,
  input  wire logic [`WDC_ADDR_W-1:0] i_addr,
  input  wire logic [`WDC_DATA_W-1:0] i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [`WDC_DATA_W-1:0] o_rdata,
  output logic                        o_chip_reset,
  output logic                        o_watchdog_enabled,
  output logic                        o_debug_port_disable
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  logic [`WDC_SYNC_W-1:0] sync1_r;
  logic [`WDC_SYNC_W-1:0] sync2_r;
  logic                   osc_prev_r;
  wire  [`WDC_SYNC_W-1:0] async_in;

  assign async_in = {i_always_on_fuse, i_legacy_compat_fuse, i_scan_reset,
                     i_brownout_reset, i_pin_reset, i_wdt_osc_clk};

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sync1_r    <= '0;
      sync2_r    <= '0;
      osc_prev_r <= 1'b0;
    end else begin
      sync1_r    <= async_in;
      sync2_r    <= sync1_r;
      osc_prev_r <= sync2_r[`WDC_SYNC_OSC];
    end
  end

  wire osc_tick   = sync2_r[`WDC_SYNC_OSC] & ~osc_prev_r;
  wire pin_rst    = sync2_r[`WDC_SYNC_PIN];
  wire bor_rst    = sync2_r[`WDC_SYNC_BOR];
  wire scan_rst   = sync2_r[`WDC_SYNC_SCAN];
  wire legacy     = sync2_r[`WDC_SYNC_LEGACY];
  wire always_on  = sync2_r[`WDC_SYNC_ALWAYS_ON];

  ////////////////////////////////////////////////////////////////////////////
  // safety level from fuses (high = programmed)

  wdc_pkg::safety_level_t level;

  assign level = always_on ? wdc_pkg::SAFETY_L2 :
                 legacy    ? wdc_pkg::SAFETY_L0 :
                             wdc_pkg::SAFETY_L1;

  wire lvl0 = (level == wdc_pkg::SAFETY_L0);
  wire lvl2 = (level == wdc_pkg::SAFETY_L2);

  ////////////////////////////////////////////////////////////////////////////
  // register decode

  wire wr_cause   = i_wr & (i_addr == `WDC_ADDR_CAUSE);
  wire wr_control = i_wr & (i_addr == `WDC_ADDR_CONTROL);

  wire w_unlock = i_wdata[`WDC_BIT_UNLOCK];
  wire w_enable = i_wdata[`WDC_BIT_ENABLE];
  wire [`WDC_SEL_W-1:0] w_sel = i_wdata[`WDC_SEL_HI:`WDC_SEL_LO];

  ////////////////////////////////////////////////////////////////////////////
  // watchdog control state

  logic                  enable_r;
  logic                  enable_nxt;
  logic [2:0]            unlock_cnt_r;
  logic [2:0]            unlock_cnt_nxt;
  logic [`WDC_SEL_W-1:0] sel_r;
  logic [`WDC_SEL_W-1:0] sel_nxt;
  logic                  expire_r;
  logic [CNT_W-1:0]      cnt_r;
  logic [CNT_W-1:0]      cnt_nxt;

  wire unlocked  = (unlock_cnt_r != `WDC_UNLOCK_ZERO);
  wire en_eff    = enable_r | lvl2;
  wire chip_rst  = i_rst | pin_rst | bor_rst | scan_rst | expire_r;
  wire start_seq = wr_control & w_unlock & w_enable;

  // enable: set by plain write, cleared only under unlock and never in level 2
  assign enable_nxt =
    !wr_control                    ? enable_r :
    w_enable                       ? 1'b1 :
    (unlocked && !lvl2)            ? 1'b0 :
                                     enable_r;

  // prescaler: free in level 0, guarded by unlock in levels 1 and 2
  assign sel_nxt =
    (wr_control && (lvl0 || unlocked)) ? w_sel : sel_r;

  // unlock window: loaded by enable+unlock write, ends after four cycles
  // or when a following control write with the unlock bit clear consumes it
  assign unlock_cnt_nxt =
    start_seq                     ? `WDC_UNLOCK_CYCLES :
    (wr_control && !w_unlock)     ? `WDC_UNLOCK_ZERO :
    unlocked                      ? unlock_cnt_r - 3'h1 :
                                    `WDC_UNLOCK_ZERO;

  always_ff @(posedge i_core_clk) begin
    if (chip_rst) begin
      enable_r     <= 1'b0;
      unlock_cnt_r <= `WDC_UNLOCK_ZERO;
      sel_r        <= `WDC_SEL_RESET;
    end else begin
      enable_r     <= enable_nxt;
      unlock_cnt_r <= unlock_cnt_nxt;
      sel_r        <= sel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // timeout counter

  logic [CNT_W-1:0] last_cnt;
  logic             expire_nxt;

  assign last_cnt = (CNT_W'(1) << (BASE_EXP + int'(sel_r))) - CNT_W'(1);
  assign expire_nxt = en_eff & osc_tick & (cnt_r == last_cnt) & !chip_rst
                      & !i_restart_instruction;

  assign cnt_nxt =
    (i_restart_instruction)        ? '0 :
    (!en_eff || expire_nxt)        ? '0 :
    osc_tick                       ? cnt_r + CNT_W'(1) :
                                     cnt_r;

  always_ff @(posedge i_core_clk) begin
    if (chip_rst) begin
      cnt_r    <= '0;
      expire_r <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      expire_r <= expire_nxt;
    end
  end

  assign o_chip_reset       = expire_r;
  assign o_watchdog_enabled = en_eff;

  ////////////////////////////////////////////////////////////////////////////
  // reset cause flags; a set in the same cycle beats a software clear

  logic [`WDC_FLAG_W-1:0] flags_r;
  logic [`WDC_FLAG_W-1:0] flags_nxt;
  logic [`WDC_FLAG_W-1:0] flag_set;
  logic [`WDC_FLAG_W-1:0] flag_mask;
  logic [`WDC_FLAG_W-1:0] flag_keep;
  logic                   dbg_r;

  assign flag_mask = legacy ? `WDC_FLAGS_LEGACY : `WDC_FLAGS_ALL;

  always_comb begin
    flag_set = `WDC_FLAGS_CLEAR;
    flag_set[`WDC_BIT_SCAN_FLAG] = scan_rst;
    flag_set[`WDC_BIT_WDT_FLAG]  = expire_r;
    flag_set[`WDC_BIT_BOR_FLAG]  = bor_rst;
    flag_set[`WDC_BIT_PIN_FLAG]  = pin_rst;
  end

  // a written zero clears, a written one keeps
  assign flag_keep = wr_cause ? i_wdata[`WDC_FLAG_W-1:0] : `WDC_FLAGS_ALL;
  assign flags_nxt = ((flags_r & flag_keep) | flag_set) & flag_mask;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      flags_r <= `WDC_FLAGS_POR_RESET;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (chip_rst) begin
      dbg_r <= 1'b0;
    end else if (wr_cause) begin
      dbg_r <= i_wdata[`WDC_BIT_DBG_DISABLE];
    end
  end

  assign o_debug_port_disable = dbg_r;

  ////////////////////////////////////////////////////////////////////////////
  // read path

  logic [`WDC_DATA_W-1:0] cause_rd;
  logic [`WDC_DATA_W-1:0] control_rd;
  logic [`WDC_DATA_W-1:0] rd_sel;
  logic [`WDC_DATA_W-1:0] rdata_r;

  always_comb begin
    cause_rd = `WDC_DATA_ZERO;
    cause_rd[`WDC_BIT_DBG_DISABLE] = dbg_r;
    cause_rd[`WDC_FLAG_W-1:0] = flags_r & flag_mask;
    control_rd = `WDC_DATA_ZERO;
    control_rd[`WDC_BIT_UNLOCK] = unlocked;
    control_rd[`WDC_BIT_ENABLE] = en_eff;
    control_rd[`WDC_SEL_HI:`WDC_SEL_LO] = sel_r;
  end

  assign rd_sel = (i_addr == `WDC_ADDR_CAUSE)   ? cause_rd :
                  (i_addr == `WDC_ADDR_CONTROL) ? control_rd :
                                                  `WDC_DATA_ZERO;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      rdata_r <= `WDC_DATA_ZERO;
    end else begin
      rdata_r <= i_rd ? rd_sel : `WDC_DATA_ZERO;
    end
  end

  assign o_rdata = rdata_r;

endmodule

// ===== verification/watchdog_with_reset_cause_properties.sv
// port-level assertions for the watchdog block
`timescale 1ns/1ps
`include "wdc_regs.svh"
module watchdog_with_reset_cause_checker #(
  parameter int CNT_W    = `WDC_CNT_W,
  parameter int BASE_EXP = `WDC_BASE_EXP
) (
  input wire logic                   i_core_clk,
  input wire logic                   i_rst,
  input wire logic                   i_wdt_osc_clk,
  input wire logic                   i_pin_reset,
  input wire logic                   i_brownout_reset,
  input wire logic                   i_scan_reset,
  input wire logic                   i_legacy_compat_fuse,
  input wire logic                   i_always_on_fuse,
  input wire logic                   i_restart_instruction,
  input wire logic [`WDC_ADDR_W-1:0] i_addr,
  input wire logic [`WDC_DATA_W-1:0] i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [`WDC_DATA_W-1:0] o_rdata,
  input wire logic                   o_chip_reset,
  input wire logic                   o_watchdog_enabled,
  input wire logic                   o_debug_port_disable
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire ctrl_wr  = i_wr && i_addr == `WDC_ADDR_CONTROL;
  wire ctrl_rd  = i_rd && i_addr == `WDC_ADDR_CONTROL;
  wire cause_rd = i_rd && i_addr == `WDC_ADDR_CAUSE;
  wire unl_wr   = ctrl_wr && i_wdata[4:3] == 2'b11;
  //////////////////////////////////////////////////////////////////////////////
  AST_CTRL_RESERVED: assert property (ctrl_rd |=> o_rdata[7:5] == 3'h0)
    else $error("control reserved bits not zero");
  AST_LEGACY_FLAGS: assert property (cause_rd && i_legacy_compat_fuse &&
    $past(i_legacy_compat_fuse, 3) |=> o_rdata[4:2] == 3'h0) else $error("legacy flags seen");
  AST_PULSE_ONE: assert property (o_chip_reset |=> !o_chip_reset)
    else $error("chip reset longer than one cycle");
  AST_LEVEL2_ON: assert property ((!i_rst && i_always_on_fuse)[*4] |-> o_watchdog_enabled)
    else $error("level 2 watchdog not enabled");
  AST_UNLOCK_EXPIRES: assert property (unl_wr ##1 (!i_wr)[*4] ##1 ctrl_rd |=> !o_rdata[4])
    else $error("unlock bit still set");
  AST_DISABLE_LOCKED: assert property (o_watchdog_enabled && ctrl_wr && !i_wdata[3] &&
    !$past(i_wr) && !$past(i_wr, 2) && !$past(i_wr, 3) && !$past(i_wr, 4)
    |=> o_watchdog_enabled || o_chip_reset) else $error("disabled without unlock");
  AST_DISABLE_TIMED: assert property (unl_wr && !i_always_on_fuse ##1 !i_wr ##1
    ctrl_wr && !i_wdata[3] |=> !o_watchdog_enabled) else $error("timed disable ignored");
  AST_ENABLE_PLAIN: assert property (ctrl_wr && i_wdata[3] && !o_chip_reset
    |=> o_watchdog_enabled) else $error("plain enable ignored");
  AST_PWRUP_CLEAR: assert property (i_wr && i_addr == `WDC_ADDR_CAUSE && !i_wdata[0]
    ##2 cause_rd |=> !o_rdata[0]) else $error("power-up flag not cleared");
  cover property (o_chip_reset);
  cover property (unl_wr ##2 ctrl_wr);
  cover property (i_restart_instruction && o_watchdog_enabled);
endmodule
bind watchdog_with_reset_cause watchdog_with_reset_cause_checker #(.CNT_W(CNT_W),
  .BASE_EXP(BASE_EXP)) chk_i (.i_core_clk, .i_rst, .i_wdt_osc_clk, .i_pin_reset,
  .i_brownout_reset, .i_scan_reset, .i_legacy_compat_fuse, .i_always_on_fuse,
  .i_restart_instruction, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .o_chip_reset,
  .o_watchdog_enabled, .o_debug_port_disable);

// ===== verification/tb_watchdog_with_reset_cause.sv
// self-checking bench for the watchdog block
`timescale 1ns/1ps
module tb_watchdog_with_reset_cause;
  logic       clk = 1'b0;
  logic       osc = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] src = 3'h0;
  logic       leg = 1'b0;
  logic       aon = 1'b0;
  logic       rs  = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic       crst;
  logic       en;
  logic       dbg;
  int         miscompares = 0;
  int         n_tests = 0;
  int         np = 0;
  int         m_flags, p, t0, d;
  int         fl[3] = '{2, 4, 16};
  watchdog_with_reset_cause #(.CNT_W(10), .BASE_EXP(2)) watchdog_with_reset_cause_i (
    .i_core_clk(clk), .i_rst(rst), .i_wdt_osc_clk(osc), .i_pin_reset(src[0]),
    .i_brownout_reset(src[1]), .i_scan_reset(src[2]), .i_legacy_compat_fuse(leg),
    .i_always_on_fuse(aon), .i_restart_instruction(rs), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_chip_reset(crst), .o_watchdog_enabled(en),
    .o_debug_port_disable(dbg));
  initial begin forever #5 clk = ~clk; end
  initial begin forever #500 osc = ~osc; end
  always @(posedge clk) if (crst === 1'b1) np++;
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] dt);
    @(posedge clk); addr <= a; wdata <= dt; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
    #1;
  endtask
  task automatic bus_rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 chk("rdata", e, rdata);
  endtask
  task automatic do_reset(input logic l, input logic o);
    @(posedge clk); rst <= 1'b1; leg <= l; aon <= o;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    m_flags = 1;
  endtask
  task automatic pulse(input int i);
    @(posedge clk); src[i] <= 1'b1;
    repeat (4) @(posedge clk);
    src[i] <= 1'b0;
    repeat (6) @(posedge clk);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hdd1a734b));
    do_reset(1'b1, 1'b0);
    chk("enable", 8'h00, {7'h0, en});
    for (int s = 0; s < 8; s++) begin
      bus_wr(4'h1, {3'($urandom()), 2'b00, 3'(s)});
      bus_rd(4'h1, 8'(s));
    end
    for (int i = 0; i < 3; i++) pulse(i);
    bus_rd(4'h0, 8'h03);
    bus_wr(4'h0, 8'h00);
    bus_rd(4'h0, 8'h00);
    do_reset(1'b0, 1'b0);
    bus_wr(4'h1, 8'h03);
    bus_rd(4'h1, 8'h00);
    for (int i = 0; i < 3; i++) begin
      pulse(i);
      m_flags |= fl[i];
      bus_rd(4'h0, 8'(m_flags));
    end
    bus_wr(4'h0, 8'h9e);
    chk("debug", 8'h01, {7'h0, dbg});
    bus_rd(4'h0, 8'h96);
    bus_wr(4'h0, 8'h00);
    bus_rd(4'h0, 8'h00);
    m_flags = 0;
    for (int s = 0; s < 4; s++) begin
      bus_wr(4'h1, 8'h18);
      bus_wr(4'h1, 8'(8 + s));
      t0 = $time;
      p = np;
      for (int k = 0; k < 40000 && np == p; k++) @(posedge clk);
      d = (2 ** (2 + s)) * 1000;
      chk("expiry", 8'h01, {7'h0, ($time - t0 > d - 1000) && ($time - t0 < d + 200)});
      m_flags |= 8;
      bus_rd(4'h0, 8'(m_flags));
      chk("enable", 8'h00, {7'h0, en});
    end
    bus_wr(4'h1, 8'h19);
    bus_wr(4'h1, 8'h09);
    p = np;
    repeat (6) begin
      repeat (400) @(posedge clk);
      rs <= 1'b1;
      @(posedge clk);
      rs <= 1'b0;
    end
    chk("pulses", 8'(p), 8'(np));
    bus_wr(4'h1, 8'h19);
    repeat (3) @(posedge clk);
    bus_rd(4'h1, 8'h09);
    bus_wr(4'h1, 8'h00);
    chk("enable", 8'h01, {7'h0, en});
    bus_wr(4'h1, 8'h19);
    bus_wr(4'h1, 8'h00);
    chk("enable", 8'h00, {7'h0, en});
    bus_wr(4'h1, 8'h08);
    chk("enable", 8'h01, {7'h0, en});
    do_reset(1'b0, 1'b1);
    chk("enable", 8'h01, {7'h0, en});
    bus_wr(4'h1, 8'h18);
    bus_wr(4'h1, 8'h00);
    bus_rd(4'h1, 8'h08);
    give_verdict();
  end
  initial begin
    #400_000;
    miscompares++;
    give_verdict();
  end
endmodule
